// file: verilog/adc_ctrl_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: 200 MHz system clock, AXI4-Lite register access
// Notes:   counts are in system clock cycles
package adc_ctrl_pkg;
	localparam int unsigned CLK_HZ             = 200000000;
	localparam int unsigned SINGLE_SHOT_CYCLES = 5129;
	localparam int unsigned REPEAT_CYCLES      = 256;
	localparam int unsigned RESULT_W           = 10;
	localparam int unsigned ADDR_W             = 4;

	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_DATA   = 4'h8;

	localparam int unsigned CTRL_START_BIT = 8;
	localparam int unsigned STAT_BUSY_BIT  = 0;
	localparam int unsigned STAT_DONE_BIT  = 1;
	localparam int unsigned STAT_UNDEF_BIT = 2;

	localparam logic [1:0] REF_EXTERNAL = 2'h0;
	localparam logic [1:0] REF_1V0      = 2'h1;
	localparam logic [1:0] REF_2V0      = 2'h2;
	localparam logic [3:0] SEL_LAST_ANA = 4'h7;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [3:0] analog_input_select;
		logic       repeat_convert_mode;
		logic       ref_pin_drive_en;
		logic       ref_level_sel_hi;
		logic       ref_level_sel_lo;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '{4'h0, 1'b0, 1'b0, 1'b1, 1'b0};
endpackage

// file: verilog/adc_conv_timer.sv
// Purpose: counts single-shot and repeating conversion periods
// Assumes: start_i is a one-cycle pulse
// Notes:   done_o is a registered one-cycle pulse
`timescale 1ns/1ps
module adc_conv_timer
	import adc_ctrl_pkg::*;
#(
	parameter int unsigned SINGLE_CYCLES = SINGLE_SHOT_CYCLES,
	parameter int unsigned REP_CYCLES    = REPEAT_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic start_i,
	input  wire logic repeat_i,
	output logic      busy_o,
	output logic      done_o
);
	localparam int unsigned MAXC = (SINGLE_CYCLES > REP_CYCLES) ? SINGLE_CYCLES : REP_CYCLES;
	localparam int unsigned CW   = $clog2(MAXC + 1);

	if (SINGLE_CYCLES < 2 || REP_CYCLES < 2) begin : g_bad
		$error("conversion periods must be at least two cycles");
	end

	logic [CW-1:0] count_r, count_nxt;
	logic          busy_r, busy_nxt;
	logic          run_r, run_nxt;
	logic          done_r, done_nxt;

	always_comb begin
		count_nxt = count_r;
		busy_nxt  = busy_r;
		run_nxt   = run_r;
		done_nxt  = 1'b0;
		if (repeat_i) begin
			if (!run_r) begin
				run_nxt   = 1'b1;
				busy_nxt  = 1'b1;
				count_nxt = '0;
			end else if (count_r == CW'(REP_CYCLES - 1)) begin
				count_nxt = '0;
				done_nxt  = 1'b1;
			end else begin
				count_nxt = count_r + 1'b1;
			end
		end else if (run_r) begin
			run_nxt   = 1'b0;
			busy_nxt  = 1'b0;
			count_nxt = '0;
		end else if (busy_r) begin
			if (count_r == CW'(SINGLE_CYCLES - 1)) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end else begin
				count_nxt = count_r + 1'b1;
			end
		end else if (start_i) begin
			busy_nxt  = 1'b1;
			count_nxt = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_r <= '0;
			busy_r  <= 1'b0;
			run_r   <= 1'b0;
			done_r  <= 1'b0;
		end else begin
			count_r <= count_nxt;
			busy_r  <= busy_nxt;
			run_r   <= run_nxt;
			done_r  <= done_nxt;
		end
	end

	assign busy_o = busy_r;
	assign done_o = done_r;
endmodule // adc_conv_timer

// file: verilog/adc_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the register file
// Assumes: one write and one read outstanding at most
// Notes:   read data is decoded by the parent from araddr
`timescale 1ns/1ps
module adc_axil_slave
	import adc_ctrl_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [ADDR_W-1:0] awaddr_i,
	input  wire logic              awvalid_i,
	output logic                   awready_o,
	input  wire logic [31:0]       wdata_i,
	input  wire logic [3:0]        wstrb_i,
	input  wire logic              wvalid_i,
	output logic                   wready_o,
	output logic [1:0]             bresp_o,
	output logic                   bvalid_o,
	input  wire logic              bready_i,
	input  wire logic              arvalid_i,
	output logic                   arready_o,
	output logic [31:0]            rdata_o,
	output logic [1:0]             rresp_o,
	output logic                   rvalid_o,
	input  wire logic              rready_i,
	output logic                   wr_en_o,
	output logic [ADDR_W-1:0]      wr_addr_o,
	output logic [31:0]            wr_data_o,
	output logic [3:0]             wr_strb_o,
	input  wire logic              wr_ok_i,
	input  wire logic [31:0]       rd_data_i,
	input  wire logic              rd_ok_i
);
	logic              awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [31:0]       wdat_r, wdat_nxt, rdat_r, rdat_nxt;
	logic [3:0]        strb_r, strb_nxt;
	logic              bval_r, bval_nxt, rval_r, rval_nxt, arrdy_r, arrdy_nxt;
	logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic              do_write;

	// both halves held, previous response gone
	assign do_write = !awrdy_r && !wrdy_r && !bval_r;

	always_comb begin
		awrdy_nxt = awrdy_r;
		wrdy_nxt  = wrdy_r;
		addr_nxt  = addr_r;
		wdat_nxt  = wdat_r;
		strb_nxt  = strb_r;
		bval_nxt  = bval_r;
		bresp_nxt = bresp_r;
		if (awvalid_i && awrdy_r) begin
			awrdy_nxt = 1'b0;
			addr_nxt  = awaddr_i;
		end
		if (wvalid_i && wrdy_r) begin
			wrdy_nxt = 1'b0;
			wdat_nxt = wdata_i;
			strb_nxt = wstrb_i;
		end
		if (bval_r && bready_i) begin
			bval_nxt = 1'b0;
		end
		if (do_write) begin
			awrdy_nxt = 1'b1;
			wrdy_nxt  = 1'b1;
			bval_nxt  = 1'b1;
			bresp_nxt = wr_ok_i ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_comb begin
		arrdy_nxt = arrdy_r;
		rval_nxt  = rval_r;
		rdat_nxt  = rdat_r;
		rresp_nxt = rresp_r;
		if (arvalid_i && arrdy_r) begin
			arrdy_nxt = 1'b0;
			rval_nxt  = 1'b1;
			rdat_nxt  = rd_data_i;
			rresp_nxt = rd_ok_i ? RESP_OKAY : RESP_SLVERR;
		end else if (rval_r && rready_i) begin
			arrdy_nxt = 1'b1;
			rval_nxt  = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			awrdy_r <= 1'b1;
			wrdy_r  <= 1'b1;
			addr_r  <= '0;
			wdat_r  <= '0;
			strb_r  <= '0;
			bval_r  <= 1'b0;
			bresp_r <= RESP_OKAY;
			arrdy_r <= 1'b1;
			rval_r  <= 1'b0;
			rdat_r  <= '0;
			rresp_r <= RESP_OKAY;
		end else begin
			awrdy_r <= awrdy_nxt;
			wrdy_r  <= wrdy_nxt;
			addr_r  <= addr_nxt;
			wdat_r  <= wdat_nxt;
			strb_r  <= strb_nxt;
			bval_r  <= bval_nxt;
			bresp_r <= bresp_nxt;
			arrdy_r <= arrdy_nxt;
			rval_r  <= rval_nxt;
			rdat_r  <= rdat_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	assign awready_o = awrdy_r;
	assign wready_o  = wrdy_r;
	assign bvalid_o  = bval_r;
	assign bresp_o   = bresp_r;
	assign arready_o = arrdy_r;
	assign rvalid_o  = rval_r;
	assign rdata_o   = rdat_r;
	assign rresp_o   = rresp_r;
	assign wr_en_o   = do_write;
	assign wr_addr_o = addr_r;
	assign wr_data_o = wdat_r;
	assign wr_strb_o = strb_r;
endmodule // adc_axil_slave

// file: verilog/adc_conversion_control.sv
// Purpose: control logic of the on-chip analog-to-digital converter
// Assumes: converter result ADC_RESULT_I is valid when a period ends
// Notes:   registers CTRL, STATUS, DATA over AXI4-Lite
//
// How it works
// - reference field 00: internal reference off, external pin reference used.
// - reference field 01: internal reference on at 1.0 V.
// - reference field 10: internal reference at 2.0 V; reset default.
// - pin drive bit 0: reference buffer off, reference pin left for GPIO.
// - pin drive bit 1: buffer on, internal reference driven to the pin.
// - repeat mode 0: one conversion, result presented after 5129 cycles.
// - repeat mode 1: result refreshed every 256 cycles until mode left.
// - select codes 0000..0111 close the switch of analog input n.
// - codes 1000..1111 open all switches; results flagged undefined.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module adc_conversion_control
	import adc_ctrl_pkg::*;
#(
	parameter int unsigned SINGLE_CYCLES = SINGLE_SHOT_CYCLES,
	parameter int unsigned REP_CYCLES    = REPEAT_CYCLES
) (
	input  wire logic                CLOCK_I,
	input  wire logic                RST_I,
	input  wire logic [ADDR_W-1:0]   S_AWADDR_I,
	input  wire logic                S_AWVALID_I,
	output logic                     S_AWREADY_O,
	input  wire logic [31:0]         S_WDATA_I,
	input  wire logic [3:0]          S_WSTRB_I,
	input  wire logic                S_WVALID_I,
	output logic                     S_WREADY_O,
	output logic [1:0]               S_BRESP_O,
	output logic                     S_BVALID_O,
	input  wire logic                S_BREADY_I,
	input  wire logic [ADDR_W-1:0]   S_ARADDR_I,
	input  wire logic                S_ARVALID_I,
	output logic                     S_ARREADY_O,
	output logic [31:0]              S_RDATA_O,
	output logic [1:0]               S_RRESP_O,
	output logic                     S_RVALID_O,
	input  wire logic                S_RREADY_I,
	input  wire logic [RESULT_W-1:0] ADC_RESULT_I,
	output logic                     INT_REF_EN_O,
	output logic                     REF_LEVEL_2V_O,
	output logic                     EXT_REF_SEL_O,
	output logic                     REF_BUF_EN_O,
	output logic                     REF_PIN_OE_O,
	output logic [7:0]               INPUT_SWITCH_O,
	output logic                     CONVERTING_O
);
	localparam int unsigned AGE_W = $clog2(SINGLE_CYCLES + 2);

	if (REP_CYCLES > SINGLE_CYCLES + 1) begin : g_bad_period
		$error("repeat period must not exceed the single-shot period");
	end

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
		reg_hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
	endfunction

	function automatic logic [7:0] switch_decode(input logic [3:0] sel);
		switch_decode = (sel <= SEL_LAST_ANA) ? (8'h01 << sel[2:0]) : 8'h00;
	endfunction

	logic              wr_en, wr_ok, rd_ok;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data, rd_data;
	logic [3:0]        wr_strb;
	logic              start_pulse, busy, done;

	ctrl_t               ctrl_r, ctrl_nxt;
	logic                done_flag_r, done_flag_nxt;
	logic                undef_r, undef_nxt;
	logic [RESULT_W-1:0] data_r, data_nxt;
	logic                int_en_r, int_en_nxt, hi_r, hi_nxt, ext_r, ext_nxt;
	logic                buf_r, buf_nxt, conv_r;
	logic [7:0]          sw_r, sw_nxt;

	adc_axil_slave u_bus (
		.clk_i     (CLOCK_I),
		.rst_i     (RST_I),
		.awaddr_i  (S_AWADDR_I),
		.awvalid_i (S_AWVALID_I),
		.awready_o (S_AWREADY_O),
		.wdata_i   (S_WDATA_I),
		.wstrb_i   (S_WSTRB_I),
		.wvalid_i  (S_WVALID_I),
		.wready_o  (S_WREADY_O),
		.bresp_o   (S_BRESP_O),
		.bvalid_o  (S_BVALID_O),
		.bready_i  (S_BREADY_I),
		.arvalid_i (S_ARVALID_I),
		.arready_o (S_ARREADY_O),
		.rdata_o   (S_RDATA_O),
		.rresp_o   (S_RRESP_O),
		.rvalid_o  (S_RVALID_O),
		.rready_i  (S_RREADY_I),
		.wr_en_o   (wr_en),
		.wr_addr_o (wr_addr),
		.wr_data_o (wr_data),
		.wr_strb_o (wr_strb),
		.wr_ok_i   (wr_ok),
		.rd_data_i (rd_data),
		.rd_ok_i   (rd_ok)
	);

	adc_conv_timer #(
		.SINGLE_CYCLES (SINGLE_CYCLES),
		.REP_CYCLES    (REP_CYCLES)
	) u_timer (
		.clk_i    (CLOCK_I),
		.rst_i    (RST_I),
		.start_i  (start_pulse),
		.repeat_i (ctrl_r.repeat_convert_mode),
		.busy_o   (busy),
		.done_o   (done)
	);

	// write decode; DATA is read-only
	assign wr_ok       = reg_hit(wr_addr, OFS_CTRL) || reg_hit(wr_addr, OFS_STATUS);
	assign start_pulse = wr_en && reg_hit(wr_addr, OFS_CTRL) && wr_strb[1]
	                     && wr_data[CTRL_START_BIT];

	always_comb begin
		rd_ok   = 1'b1;
		rd_data = 32'h0;
		if (reg_hit(S_ARADDR_I, OFS_CTRL)) begin
			rd_data[7:0] = ctrl_r;
		end else if (reg_hit(S_ARADDR_I, OFS_STATUS)) begin
			rd_data[STAT_BUSY_BIT]  = busy;
			rd_data[STAT_DONE_BIT]  = done_flag_r;
			rd_data[STAT_UNDEF_BIT] = undef_r;
		end else if (reg_hit(S_ARADDR_I, OFS_DATA)) begin
			rd_data[RESULT_W-1:0] = data_r;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_comb begin
		ctrl_nxt      = ctrl_r;
		done_flag_nxt = done_flag_r;
		undef_nxt     = undef_r;
		data_nxt      = data_r;
		if (wr_en && reg_hit(wr_addr, OFS_CTRL) && wr_strb[0]) begin
			ctrl_nxt = wr_data[7:0];
		end
		if (wr_en && reg_hit(wr_addr, OFS_STATUS) && wr_strb[0]
		    && wr_data[STAT_DONE_BIT]) begin
			done_flag_nxt = 1'b0;
		end
		if (done) begin
			data_nxt      = ADC_RESULT_I;
			done_flag_nxt = 1'b1;
			undef_nxt     = ctrl_r.analog_input_select[3];
		end
	end

	always_comb begin
		int_en_nxt = ({ctrl_r.ref_level_sel_hi, ctrl_r.ref_level_sel_lo} == REF_1V0)
		             || ({ctrl_r.ref_level_sel_hi, ctrl_r.ref_level_sel_lo} == REF_2V0);
		hi_nxt     = ({ctrl_r.ref_level_sel_hi, ctrl_r.ref_level_sel_lo} == REF_2V0);
		ext_nxt    = !int_en_nxt;
		buf_nxt    = ctrl_r.ref_pin_drive_en;
		sw_nxt     = switch_decode(ctrl_r.analog_input_select);
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			ctrl_r      <= CTRL_RESET;
			done_flag_r <= 1'b0;
			undef_r     <= 1'b0;
			data_r      <= '0;
			int_en_r    <= 1'b1;
			hi_r        <= 1'b1;
			ext_r       <= 1'b0;
			buf_r       <= 1'b0;
			sw_r        <= 8'h01;
			conv_r      <= 1'b0;
		end else begin
			ctrl_r      <= ctrl_nxt;
			done_flag_r <= done_flag_nxt;
			undef_r     <= undef_nxt;
			data_r      <= data_nxt;
			int_en_r    <= int_en_nxt;
			hi_r        <= hi_nxt;
			ext_r       <= ext_nxt;
			buf_r       <= buf_nxt;
			sw_r        <= sw_nxt;
			conv_r      <= busy;
		end
	end

	assign INT_REF_EN_O   = int_en_r;
	assign REF_LEVEL_2V_O = hi_r;
	assign EXT_REF_SEL_O  = ext_r;
	assign REF_BUF_EN_O   = buf_r;
	assign REF_PIN_OE_O   = buf_r;
	assign INPUT_SWITCH_O = sw_r;
	assign CONVERTING_O   = conv_r;

	// checking helpers: cycles since start and since last period end
	logic [AGE_W-1:0] age_r, gap_r;
	logic             rep_seen_r;
	logic             mode_q_r;
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			age_r      <= '0;
			gap_r      <= '0;
			rep_seen_r <= 1'b0;
			mode_q_r   <= 1'b0;
		end else begin
			mode_q_r <= ctrl_r.repeat_convert_mode;
			if (start_pulse && !busy) begin
				age_r <= '0;
			end else if (age_r != '1) begin
				age_r <= age_r + 1'b1;
			end
			if (done) begin
				gap_r <= '0;
			end else if (gap_r != '1) begin
				gap_r <= gap_r + 1'b1;
			end
			rep_seen_r <= ctrl_r.repeat_convert_mode && (rep_seen_r || (done && mode_q_r));
		end
	end

	property p_ref_off;
		@(posedge CLOCK_I) disable iff (RST_I)
		({ctrl_r.ref_level_sel_hi, ctrl_r.ref_level_sel_lo} == REF_EXTERNAL)
		|=> !INT_REF_EN_O && EXT_REF_SEL_O;
	endproperty
	a_ref_off: assert property (p_ref_off) else $error("reference not external");

	property p_ref_1v;
		@(posedge CLOCK_I) disable iff (RST_I)
		({ctrl_r.ref_level_sel_hi, ctrl_r.ref_level_sel_lo} == REF_1V0)
		|=> INT_REF_EN_O && !REF_LEVEL_2V_O && !EXT_REF_SEL_O;
	endproperty
	a_ref_1v: assert property (p_ref_1v) else $error("1.0 V reference wrong");

	property p_ref_2v;
		@(posedge CLOCK_I) disable iff (RST_I)
		$past(RST_I) |-> ctrl_r.ref_level_sel_hi && !ctrl_r.ref_level_sel_lo
		                 && INT_REF_EN_O && REF_LEVEL_2V_O;
	endproperty
	a_ref_2v: assert property (p_ref_2v) else $error("reset level not 2.0 V");

	property p_ref_2v_sel;
		@(posedge CLOCK_I) disable iff (RST_I)
		({ctrl_r.ref_level_sel_hi, ctrl_r.ref_level_sel_lo} == REF_2V0)
		|=> INT_REF_EN_O && REF_LEVEL_2V_O && !EXT_REF_SEL_O;
	endproperty
	a_ref_2v_sel: assert property (p_ref_2v_sel) else $error("2.0 V reference wrong");

	property p_buf_off;
		@(posedge CLOCK_I) disable iff (RST_I)
		!ctrl_r.ref_pin_drive_en |=> !REF_BUF_EN_O && !REF_PIN_OE_O;
	endproperty
	a_buf_off: assert property (p_buf_off) else $error("reference pin driven");

	property p_buf_on;
		@(posedge CLOCK_I) disable iff (RST_I)
		ctrl_r.ref_pin_drive_en |=> REF_BUF_EN_O && REF_PIN_OE_O;
	endproperty
	a_buf_on: assert property (p_buf_on) else $error("reference pin not driven");

	property p_single;
		@(posedge CLOCK_I) disable iff (RST_I)
		done && !mode_q_r |-> age_r == AGE_W'(SINGLE_CYCLES)
		##1 data_r == $past(ADC_RESULT_I);
	endproperty
	a_single: assert property (p_single) else $error("single-shot timing wrong");

	property p_repeat;
		@(posedge CLOCK_I) disable iff (RST_I)
		done && rep_seen_r && ctrl_r.repeat_convert_mode |-> gap_r == AGE_W'(REP_CYCLES - 1);
	endproperty
	a_repeat: assert property (p_repeat) else $error("repeat period wrong");

	property p_switch;
		@(posedge CLOCK_I) disable iff (RST_I)
		!ctrl_r.analog_input_select[3] |=> $onehot(INPUT_SWITCH_O)
		&& INPUT_SWITCH_O[$past(ctrl_r.analog_input_select[2:0])];
	endproperty
	a_switch: assert property (p_switch) else $error("input switch wrong");

	property p_reserved;
		@(posedge CLOCK_I) disable iff (RST_I)
		ctrl_r.analog_input_select[3] |=> INPUT_SWITCH_O == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved select mishandled");

	property p_undef;
		@(posedge CLOCK_I) disable iff (RST_I)
		done |=> undef_r == $past(ctrl_r.analog_input_select[3]);
	endproperty
	a_undef: assert property (p_undef) else $error("undefined mark wrong");

	c_single: cover property (@(posedge CLOCK_I) disable iff (RST_I)
		done && !ctrl_r.repeat_convert_mode);
	c_repeat: cover property (@(posedge CLOCK_I) disable iff (RST_I)
		done && rep_seen_r);
	c_undef: cover property (@(posedge CLOCK_I) disable iff (RST_I)
		done && ctrl_r.analog_input_select[3]);
	c_pin_drive: cover property (@(posedge CLOCK_I) disable iff (RST_I)
		ctrl_r.ref_pin_drive_en && REF_PIN_OE_O);
endmodule // adc_conversion_control

// file: tb/tb.sv
// Purpose: self-checking bench for the converter control block
// Assumes: small period counts, AXI4-Lite master driven from tasks
// Notes:   inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
module tb;
	import adc_ctrl_pkg::*;
	localparam int unsigned S = 20;
	localparam int unsigned R = 8;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic [ADDR_W-1:0]   awaddr = '0;
	logic [ADDR_W-1:0]   araddr = '0;
	logic                awvalid = 1'b0;
	logic                wvalid = 1'b0;
	logic                bready = 1'b0;
	logic                arvalid = 1'b0;
	logic                rready = 1'b0;
	logic [31:0]         wdata = '0;
	logic [3:0]          wstrb = '0;
	logic [RESULT_W-1:0] adc_res = '0;
	logic                awready, wready, bvalid, arready, rvalid;
	logic [1:0]          bresp, rresp;
	logic [31:0]         rdata;
	logic                int_ref, lvl_2v, ext_sel, buf_en, pin_oe, conv;
	logic [7:0]          sw;
	int                  num_errors = 0;
	int                  n_tests = 0;
	logic [31:0]         rd;
	logic [1:0]          rsp;

	always #2.5 clk = ~clk;

	adc_conversion_control #(.SINGLE_CYCLES(S), .REP_CYCLES(R)) dut_u (
		.CLOCK_I(clk), .RST_I(rst),
		.S_AWADDR_I(awaddr), .S_AWVALID_I(awvalid), .S_AWREADY_O(awready),
		.S_WDATA_I(wdata), .S_WSTRB_I(wstrb), .S_WVALID_I(wvalid), .S_WREADY_O(wready),
		.S_BRESP_O(bresp), .S_BVALID_O(bvalid), .S_BREADY_I(bready),
		.S_ARADDR_I(araddr), .S_ARVALID_I(arvalid), .S_ARREADY_O(arready),
		.S_RDATA_O(rdata), .S_RRESP_O(rresp), .S_RVALID_O(rvalid), .S_RREADY_I(rready),
		.ADC_RESULT_I(adc_res), .INT_REF_EN_O(int_ref), .REF_LEVEL_2V_O(lvl_2v),
		.EXT_REF_SEL_O(ext_sel), .REF_BUF_EN_O(buf_en), .REF_PIN_OE_O(pin_oe),
		.INPUT_SWITCH_O(sw), .CONVERTING_O(conv)
	);

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
			output logic [1:0] resp);
		logic aw_t, w_t, b_t;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever begin
			@(negedge clk);
			aw_t = awvalid && awready;
			w_t  = wvalid && wready;
			b_t  = bvalid && bready;
			resp = bresp;
			@(posedge clk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			if (b_t) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
			output logic [1:0] resp);
		logic ar_t, r_t;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever begin
			@(negedge clk);
			ar_t = arvalid && arready;
			r_t  = rvalid && rready;
			d    = rdata;
			resp = rresp;
			@(posedge clk);
			if (ar_t) arvalid <= 1'b0;
			if (r_t) begin
				rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic t_reset();
		@(negedge clk);
		chk("int_ref", int_ref, 1);
		chk("lvl_2v", lvl_2v, 1);
		chk("pin_oe", pin_oe, 0);
		chk("buf_en", buf_en, 0);
		chk("ext_sel", ext_sel, 0);
		chk("converting", conv, 0);
		chk("switch", sw, 8'h01);
		axi_rd(OFS_CTRL, rd, rsp);
		chk("ctrl", rd, 32'h2);
	endtask

	task automatic t_ref();
		logic on;
		for (int lvl = 0; lvl < 4; lvl++) begin
			for (int drv = 0; drv < 2; drv++) begin
				axi_wr(OFS_CTRL, 32'(lvl) | (32'(drv) << 2), rsp);
				@(negedge clk);
				on = (lvl == 1) || (lvl == 2);
				chk("int_ref", int_ref, on);
				chk("ext_sel", ext_sel, !on);
				if (on) chk("lvl_2v", lvl_2v, lvl == 2);
				chk("buf_en", buf_en, drv);
				chk("pin_oe", pin_oe, drv);
			end
		end
	endtask

	task automatic t_select();
		for (int s = 0; s < 16; s++) begin
			axi_wr(OFS_CTRL, (32'(s) << 4) | 32'h2, rsp);
			@(negedge clk);
			chk("switch", sw, (s < 8) ? (8'h01 << s) : 8'h00);
		end
	endtask

	task automatic t_single();
		@(posedge clk);
		adc_res <= 10'h2a5;
		axi_wr(OFS_CTRL, 32'h102, rsp);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("converting", conv, 1);
		repeat (S - 8) @(posedge clk);
		axi_rd(OFS_STATUS, rd, rsp);
		chk("early status", rd[2:0], 3'b001);
		repeat (4) @(posedge clk);
		axi_rd(OFS_STATUS, rd, rsp);
		chk("late status", rd[2:0], 3'b010);
		axi_rd(OFS_DATA, rd, rsp);
		chk("data", rd, 32'h2a5);
		adc_res <= 10'h15a;
		repeat (3 * S) @(posedge clk);
		axi_rd(OFS_DATA, rd, rsp);
		chk("data once", rd, 32'h2a5);
		@(negedge clk);
		chk("idle", conv, 0);
		axi_wr(OFS_STATUS, 32'h2, rsp);
		axi_rd(OFS_STATUS, rd, rsp);
		chk("done cleared", rd[1], 0);
	endtask

	task automatic t_undef();
		axi_wr(OFS_CTRL, 32'h182, rsp);
		repeat (S + 4) @(posedge clk);
		axi_rd(OFS_STATUS, rd, rsp);
		chk("undefined", rd[2:1], 2'b11);
		axi_wr(OFS_STATUS, 32'h2, rsp);
	endtask

	task automatic t_repeat();
		adc_res <= 10'h0c3;
		axi_wr(OFS_CTRL, 32'h0a, rsp);
		repeat (R + 6) @(posedge clk);
		axi_rd(OFS_DATA, rd, rsp);
		chk("rep data 1", rd, 32'h0c3);
		@(negedge clk);
		chk("converting", conv, 1);
		@(posedge clk);
		adc_res <= 10'h33c;
		repeat (R + 3) @(posedge clk);
		axi_rd(OFS_DATA, rd, rsp);
		chk("rep data 2", rd, 32'h33c);
		adc_res <= 10'h111;
		repeat (R + 3) @(posedge clk);
		axi_rd(OFS_DATA, rd, rsp);
		chk("rep data 3", rd, 32'h111);
		axi_wr(OFS_CTRL, 32'h02, rsp);
		adc_res <= 10'h222;
		repeat (4 * R) @(posedge clk);
		axi_rd(OFS_DATA, rd, rsp);
		chk("rep stopped", rd, 32'h111);
		@(negedge clk);
		chk("stopped", conv, 0);
	endtask

	task automatic t_bus_err();
		axi_wr(4'hc, 32'h0d, rsp);
		chk("unmapped wr", rsp, RESP_SLVERR);
		axi_wr(OFS_DATA, 32'h0d, rsp);
		chk("data wr", rsp, RESP_SLVERR);
		axi_rd(4'hc, rd, rsp);
		chk("unmapped rd", rsp, RESP_SLVERR);
		chk("unmapped data", rd, 32'h0);
		axi_rd(OFS_CTRL, rd, rsp);
		chk("ctrl kept", rd, 32'h2);
		chk("ctrl resp", rsp, RESP_OKAY);
	endtask

	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (2000) @(posedge clk);
		num_errors++;
		final_report();
	end

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_ref();
		t_select();
		t_single();
		t_undef();
		t_repeat();
		t_bus_err();
		final_report();
	end
endmodule // tb
